// [rtl/gpio_alt_function.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - With calibration enabled, count fast cycles over two slow clock periods into 12 bits.
// R2 - A trimmed part reads a ratio near two thousand.
// R3 - One register holds pin one select at 12:8 and pin zero at 4:0.
// R4 - Code zero gives legacy behaviour: pin one photodiode sync, pin zero interrupt.
// R5 - Code one routes the device interrupt to the pin.
// R6 - Code two asserts from first slot start to last slot end.
// R7 - Codes five, six, seven give slot A, slot B, both slot pulses.
// R8 - Codes twelve, thirteen, fourteen flag data cycles for A, B, any slot.
// R9 - Code fifteen toggles every sample, half the sample rate.
// R10 - Codes sixteen and seventeen force low and high; others are unsupported.
// R11 - Code nineteen routes the slow oscillator to the pin.
// R12 - Drive mode zero drives always; one drives only while active, open drain.
// R13 - Polarity zero is active high; one is active low.
// R14 - Slow edges are synchronised; ratio updates only after complete measurement.
// R15 - After reset selects and ratio read zero.
module gpio_alt_function
  import gpio_mux_pkg::*;
(
  input wire logic clk, // 100 MHz fast clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [REG_AW-1:0] reg_addr, // Register index.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [REG_DW-1:0] reg_wdata, // Write data.
  output logic [REG_DW-1:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  input wire logic fast_clock_calibration_enable, // Starts ratio measurement.
  input wire logic pin_zero_drive_mode, // 1 = open drain.
  input wire logic pin_zero_polarity, // 1 = active low.
  input wire logic pin_one_drive_mode, // 1 = open drain.
  input wire logic pin_one_polarity, // 1 = active low.
  input wire pin_events_t events, // Selectable sources.
  output logic general_pin_zero_out, // Pin zero level.
  output logic general_pin_zero_oe, // Pin zero enable.
  output logic general_pin_one_out, // Pin one level.
  output logic general_pin_one_oe // Pin one enable.
);

  typedef struct packed {
    logic [SEL_W-1:0] sel_one;
    logic [SEL_W-1:0] sel_zero;
    logic half_rate;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [REG_DW-1:0] rdata;
  } gpio_state_t;

  gpio_state_t st;
  gpio_state_t next_st;
  logic [RATIO_W-1:0] ratio;
  logic ratio_done;
  logic [1:0] active;
  logic [1:0] drive_out;
  logic [1:0] drive_oe;
  pin_cfg_t [1:0] cfg;
  logic [1:0][SEL_W-1:0] sel;
  logic [1:0] legacy;

  ////////////////////////////////////////////////////////////////////////////
  // Ratio measurement.

  clock_ratio_counter #(
    .W(RATIO_W)
  ) u_ratio (
    .clk(clk),
    .rst(rst),
    .enable(fast_clock_calibration_enable),
    .slow_clock(events.slow_osc),
    .ratio(ratio),
    .done(ratio_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin function multiplexer.

  assign cfg[0] = '{drive_mode: pin_zero_drive_mode, polarity: pin_zero_polarity};
  assign cfg[1] = '{drive_mode: pin_one_drive_mode, polarity: pin_one_polarity};
  assign sel[0] = st.sel_zero;
  assign sel[1] = st.sel_one;
  assign legacy[0] = events.interrupt; // R4
  assign legacy[1] = events.photodiode_sync; // R4

  for (genvar i = 0; i < 2; i++) begin : g_pin
    // R5 R6 R7 R8 R9 R10 R11
    assign active[i] = pin_level(sel[i], events, st.half_rate, legacy[i]);
    assign drive_out[i] = active[i] ^ cfg[i].polarity; // R13
    // Open drain only drives while asserted, so several parts can share the line.
    assign drive_oe[i] = cfg[i].drive_mode ? active[i] : 1'b1; // R12
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update and register access.

  always_comb begin
    next_st = st;
    next_st.pin_out = drive_out;
    next_st.pin_oe = drive_oe;
    if (events.sample_tick) begin
      next_st.half_rate = ~st.half_rate; // R9
    end
    if (reg_wr && reg_addr == ADDR_PIN_FUNCTION_SELECT) begin
      next_st.sel_one = reg_wdata[SEL_ONE_LSB +: SEL_W]; // R3
      next_st.sel_zero = reg_wdata[SEL_ZERO_LSB +: SEL_W]; // R3
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CLOCK_RATIO_RESULT: next_st.rdata = {{(REG_DW-RATIO_W){1'b0}}, ratio}; // R1 R2
        ADDR_PIN_FUNCTION_SELECT: begin
          next_st.rdata = '0;
          next_st.rdata[SEL_ONE_LSB +: SEL_W] = st.sel_one;
          next_st.rdata[SEL_ZERO_LSB +: SEL_W] = st.sel_zero;
        end
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0; // R15
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign general_pin_zero_out = st.pin_out[0];
  assign general_pin_zero_oe = st.pin_oe[0];
  assign general_pin_one_out = st.pin_out[1];
  assign general_pin_one_oe = st.pin_oe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_select_write;
    @(posedge clk) disable iff (rst) (reg_wr && reg_addr == ADDR_PIN_FUNCTION_SELECT)
      |=> st.sel_one == $past(reg_wdata[SEL_ONE_LSB +: SEL_W])
      && st.sel_zero == $past(reg_wdata[SEL_ZERO_LSB +: SEL_W]);
  endproperty
  a_select_write: assert property (p_select_write) else $error("select write not stored"); // R3

  property p_force_levels;
    @(posedge clk) disable iff (rst) (st.sel_zero == FN_FORCE_HIGH && !pin_zero_polarity)
      |=> general_pin_zero_out && general_pin_zero_oe == 1'b1;
  endproperty
  a_force_levels: assert property (p_force_levels) else $error("forced high not driven"); // R10

  property p_legacy_interrupt;
    @(posedge clk) disable iff (rst) (st.sel_zero == FN_LEGACY && !pin_zero_polarity)
      |=> general_pin_zero_out == $past(events.interrupt);
  endproperty
  a_legacy_interrupt: assert property (p_legacy_interrupt) // R4
    else $error("legacy pin zero wrong");

  property p_slow_osc_route;
    @(posedge clk) disable iff (rst) (st.sel_one == FN_SLOW_OSC && pin_one_polarity)
      |=> general_pin_one_out == !$past(events.slow_osc);
  endproperty
  a_slow_osc_route: assert property (p_slow_osc_route) // R11 R13
    else $error("oscillator route wrong");

  property p_open_drain;
    @(posedge clk) disable iff (rst) (pin_zero_drive_mode && st.sel_zero == FN_INTERRUPT)
      |=> general_pin_zero_oe == $past(events.interrupt);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain enable wrong"); // R12 R5

  property p_half_rate;
    @(posedge clk) disable iff (rst) events.sample_tick |=> st.half_rate != $past(st.half_rate);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate did not toggle"); // R9

  property p_ratio_read;
    @(posedge clk) disable iff (rst) (reg_rd && reg_addr == ADDR_CLOCK_RATIO_RESULT)
      |=> reg_rdata[RATIO_W-1:0] == $past(ratio) && reg_rdata[REG_DW-1:RATIO_W] == '0;
  endproperty
  a_ratio_read: assert property (p_ratio_read) else $error("ratio read wrong"); // R1

  property p_done_needs_enable;
    @(posedge clk) disable iff (rst) ratio_done |-> $past(fast_clock_calibration_enable);
  endproperty
  a_done_needs_enable: assert property (p_done_needs_enable) // R1
    else $error("ratio stored while calibration was off");

  // Slow edges are at least two clocks apart, so a stored count is a single pulse.
  property p_done_single;
    @(posedge clk) disable iff (rst) ratio_done |=> !ratio_done;
  endproperty
  a_done_single: assert property (p_done_single) // R14
    else $error("ratio done longer than one cycle");

  property p_select_reserved;
    @(posedge clk) disable iff (rst) (reg_rd && reg_addr == ADDR_PIN_FUNCTION_SELECT)
      |=> reg_rdata[REG_DW-1:SEL_ONE_LSB+SEL_W] == '0
      && reg_rdata[SEL_ONE_LSB-1:SEL_ZERO_LSB+SEL_W] == '0;
  endproperty
  a_select_reserved: assert property (p_select_reserved) // R3
    else $error("reserved select bits not zero");

  property p_legacy_sync;
    @(posedge clk) disable iff (rst) (st.sel_one == FN_LEGACY)
      |=> general_pin_one_out == ($past(events.photodiode_sync) ^ $past(pin_one_polarity));
  endproperty
  a_legacy_sync: assert property (p_legacy_sync) // R4 R13
    else $error("legacy pin one wrong");

  property p_slot_window;
    @(posedge clk) disable iff (rst) (st.sel_zero == FN_SLOT_WINDOW)
      |=> general_pin_zero_out == ($past(events.slot_window) ^ $past(pin_zero_polarity));
  endproperty
  a_slot_window: assert property (p_slot_window) // R6 R13
    else $error("slot window route wrong");

  property p_pulse_both;
    @(posedge clk) disable iff (rst) (st.sel_one == FN_PULSE_AB)
      |=> general_pin_one_out
      == (($past(events.slot_a_pulse) | $past(events.slot_b_pulse)) ^ $past(pin_one_polarity));
  endproperty
  a_pulse_both: assert property (p_pulse_both) // R7
    else $error("combined pulse route wrong");

  property p_data_any;
    @(posedge clk) disable iff (rst) (st.sel_zero == FN_DATA_ANY)
      |=> general_pin_zero_out
      == (($past(events.slot_a_data_cycle) | $past(events.slot_b_data_cycle))
      ^ $past(pin_zero_polarity));
  endproperty
  a_data_any: assert property (p_data_any) // R8
    else $error("data cycle route wrong");

  property p_half_rate_pin;
    @(posedge clk) disable iff (rst) (st.sel_zero == FN_HALF_RATE)
      |=> general_pin_zero_out == ($past(st.half_rate) ^ $past(pin_zero_polarity));
  endproperty
  a_half_rate_pin: assert property (p_half_rate_pin) // R9 R13
    else $error("half rate not on pin");

  // Forced low is a level before polarity, so an active-low pin shows high.
  property p_force_low;
    @(posedge clk) disable iff (rst) (st.sel_one == FN_FORCE_LOW)
      |=> general_pin_one_out == $past(pin_one_polarity)
      && general_pin_one_oe == !$past(pin_one_drive_mode);
  endproperty
  a_force_low: assert property (p_force_low) // R10 R12
    else $error("forced low not driven");

endmodule : gpio_alt_function
`default_nettype wire

// [shared/gpio_mux_pkg.sv]
package gpio_mux_pkg;

  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 16;
  localparam logic [REG_AW-1:0] ADDR_CLOCK_RATIO_RESULT = 8'h0a;
  localparam logic [REG_AW-1:0] ADDR_PIN_FUNCTION_SELECT = 8'h0b;

  localparam int unsigned SEL_W = 5;
  localparam int unsigned SEL_ONE_LSB = 8;
  localparam int unsigned SEL_ZERO_LSB = 0;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;

  localparam int unsigned RATIO_W = 12;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 12'h000;
  localparam logic [RATIO_W-1:0] RATIO_NOMINAL = 12'h7d0;
  localparam logic [1:0] SLOW_PERIODS = 2'h2;

  localparam logic [SEL_W-1:0] FN_LEGACY = 5'h00;
  localparam logic [SEL_W-1:0] FN_INTERRUPT = 5'h01;
  localparam logic [SEL_W-1:0] FN_SLOT_WINDOW = 5'h02;
  localparam logic [SEL_W-1:0] FN_PULSE_A = 5'h05;
  localparam logic [SEL_W-1:0] FN_PULSE_B = 5'h06;
  localparam logic [SEL_W-1:0] FN_PULSE_AB = 5'h07;
  localparam logic [SEL_W-1:0] FN_DATA_A = 5'h0c;
  localparam logic [SEL_W-1:0] FN_DATA_B = 5'h0d;
  localparam logic [SEL_W-1:0] FN_DATA_ANY = 5'h0e;
  localparam logic [SEL_W-1:0] FN_HALF_RATE = 5'h0f;
  localparam logic [SEL_W-1:0] FN_FORCE_LOW = 5'h10;
  localparam logic [SEL_W-1:0] FN_FORCE_HIGH = 5'h11;
  localparam logic [SEL_W-1:0] FN_SLOW_OSC = 5'h13;

  // Event sources from the sequencer and the interrupt logic; all levels sampled on clk.
  typedef struct packed {
    logic interrupt;
    logic photodiode_sync;
    logic slot_window;
    logic slot_a_pulse;
    logic slot_b_pulse;
    logic slot_a_data_cycle;
    logic slot_b_data_cycle;
    logic sample_tick;
    logic slow_osc;
  } pin_events_t;

  typedef struct packed {
    logic drive_mode;
    logic polarity;
  } pin_cfg_t;

  // Active level of a pin before polarity. Unsupported codes give the inactive level.
  function automatic logic pin_level(input logic [SEL_W-1:0] sel, input pin_events_t ev,
                                     input logic half_rate, input logic legacy);
    logic lvl;
    lvl = 1'b0;
    case (sel)
      FN_LEGACY: lvl = legacy;
      FN_INTERRUPT: lvl = ev.interrupt;
      FN_SLOT_WINDOW: lvl = ev.slot_window;
      FN_PULSE_A: lvl = ev.slot_a_pulse;
      FN_PULSE_B: lvl = ev.slot_b_pulse;
      FN_PULSE_AB: lvl = ev.slot_a_pulse | ev.slot_b_pulse;
      FN_DATA_A: lvl = ev.slot_a_data_cycle;
      FN_DATA_B: lvl = ev.slot_b_data_cycle;
      FN_DATA_ANY: lvl = ev.slot_a_data_cycle | ev.slot_b_data_cycle;
      FN_HALF_RATE: lvl = half_rate;
      FN_FORCE_LOW: lvl = 1'b0;
      FN_FORCE_HIGH: lvl = 1'b1;
      FN_SLOW_OSC: lvl = ev.slow_osc;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction : pin_level

endpackage : gpio_mux_pkg

// [rtl/clock_ratio_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_ratio_counter
  import gpio_mux_pkg::*;
#(
  parameter int unsigned W = RATIO_W
) (
  input wire logic clk, // Fast clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic enable, // Calibration enable.
  input wire logic slow_clock, // Slow oscillator.
  output logic [W-1:0] ratio, // Last complete count.
  output logic done // Pulse when a new count is stored.
);

  typedef enum {IDLE, COUNT} ratio_phase_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic counting;
    logic [1:0] periods;
    logic [W-1:0] count;
    logic [W-1:0] result;
    logic done;
  } ratio_state_t;

  ratio_state_t st;
  ratio_state_t next_st;
  ratio_phase_t phase;
  logic rise;

  assign rise = st.s2 & ~st.s3;
  assign phase = st.counting ? COUNT : IDLE;

  always_comb begin
    next_st = st;
    next_st.s1 = slow_clock; // R14
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.done = 1'b0;
    if (!enable) begin
      next_st.counting = 1'b0;
      next_st.periods = 2'h0;
      next_st.count = '0;
    end else begin
      case (phase)
        IDLE: begin
          if (rise) begin
            next_st.counting = 1'b1;
            next_st.periods = 2'h0;
            next_st.count = '0;
          end
        end
        COUNT: begin
          // Saturate so a stalled slow clock cannot wrap into a plausible value.
          if (st.count != {W{1'b1}}) begin
            next_st.count = st.count + 1'b1; // R1
          end
          if (rise) begin
            if (st.periods + 2'h1 == SLOW_PERIODS) begin
              next_st.result = next_st.count; // R1 R14
              next_st.done = 1'b1;
              next_st.periods = 2'h0;
              next_st.count = '0;
            end else begin
              next_st.periods = st.periods + 2'h1;
            end
          end
        end
        default: next_st.counting = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0; // R15
    end else begin
      st <= next_st;
    end
  end

  assign ratio = st.result;
  assign done = st.done;

  property p_result_only_on_done;
    @(posedge clk) disable iff (rst) (st.result != $past(st.result)) |-> st.done;
  endproperty
  a_result_only_on_done: assert property (p_result_only_on_done) // R14
    else $error("ratio changed without done");

  property p_idle_when_disabled;
    @(posedge clk) disable iff (rst) !enable |=> (st.count == '0) && !st.counting && !st.done;
  endproperty
  a_idle_when_disabled: assert property (p_idle_when_disabled) // R1
    else $error("counter active while disabled");

  property p_counts_up;
    @(posedge clk) disable iff (rst)
      (enable && st.counting && !rise && st.count != {W{1'b1}})
      |=> st.count == $past(st.count) + 1'b1;
  endproperty
  a_counts_up: assert property (p_counts_up) else $error("ratio count did not advance"); // R1

endmodule : clock_ratio_counter
`default_nettype wire

// [sim/event_source.sv]
`timescale 1ns/1ps
`default_nettype none
module event_source
  import gpio_mux_pkg::*;
#(
  parameter int HALF = 20
) (
  input wire logic clk, // Fast clock.
  input wire logic rst, // Reset, active high.
  input wire pin_events_t pattern, // Levels commanded by the bench.
  input wire logic osc_run, // Runs the slow oscillator.
  output var pin_events_t events // Sources seen by the block.
);
  int cnt;
  logic osc;
  // The slow oscillator stands low while stopped, so no stray edge starts a count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      osc <= 1'b0;
    end else if (!osc_run) begin
      cnt <= 0;
      osc <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 1;
    end
  end
  always_comb begin
    events = pattern;
    events.slow_osc = pattern.slow_osc | osc;
  end
endmodule : event_source
`default_nettype wire

// [sim/gpio_alt_function_test.sv]
`timescale 1ns/1ps
`default_nettype none
module gpio_alt_function_test;
  import gpio_mux_pkg::*;
  // A slow half period of 500 clocks puts the nominal two thousand in two slow periods.
  localparam int HALF = 500;
  logic clk, rst, reg_wr, reg_rd, cal_en, osc_run, l0, l1;
  logic out0, oe0, out1, oe1;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata, rd_val;
  pin_events_t pattern, events;
  int errors, cmp_count;
  logic [SEL_W-1:0] codes [13] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0c,
                                   5'h0d, 5'h0e, 5'h10, 5'h11, 5'h13, 5'h0f};
  ////////////////////////////////////////////////////////////////////////////////
  // Pin zero is open drain active high, pin one push-pull active low.
  gpio_alt_function u_gpio_alt_function (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fast_clock_calibration_enable(cal_en), .pin_zero_drive_mode(1'b1),
    .pin_zero_polarity(1'b0), .pin_one_drive_mode(1'b0), .pin_one_polarity(1'b1),
    .events(events), .general_pin_zero_out(out0), .general_pin_zero_oe(oe0),
    .general_pin_one_out(out1), .general_pin_one_oe(oe1));
  event_source #(.HALF(HALF)) u_event_source (.clk(clk), .rst(rst), .pattern(pattern),
    .osc_run(osc_run), .events(events));
  ////////////////////////////////////////////////////////////////////////////////
  task tick;
    @(posedge clk);
    #1;
  endtask : tick
  task reg_write(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    // One idle edge between accesses keeps back-to-back strobes as separate pulses.
    tick;
  endtask : reg_write
  task reg_read(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    d = reg_rdata;
    tick;
  endtask : reg_read
  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task give_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Active level before polarity, pin one when one is set.
  function automatic logic lvl(input logic [4:0] c, input logic [8:0] e, input logic one);
    case (c)
      5'h00: return one ? e[7] : e[8];
      5'h01: return e[8];
      5'h02: return e[6];
      5'h05: return e[5];
      5'h06: return e[4];
      5'h07: return e[5] | e[4];
      5'h0c: return e[3];
      5'h0d: return e[2];
      5'h0e: return e[3] | e[2];
      5'h0f: return 1'b0; // No sample tick comes before this scan, so half rate is low.
      5'h11: return 1'b1;
      5'h13: return e[0];
      default: return 1'b0;
    endcase
  endfunction : lvl
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    give_verdict;
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, cal_en, osc_run} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    pattern = pin_events_t'(9'h000);
    errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    tick;
    reg_read(ADDR_CLOCK_RATIO_RESULT, rd_val);
    check(rd_val, 16'h0000);
    reg_read(ADDR_PIN_FUNCTION_SELECT, rd_val);
    check(rd_val, 16'h0000);
    reg_write(ADDR_PIN_FUNCTION_SELECT, 16'hffff);
    reg_read(ADDR_PIN_FUNCTION_SELECT, rd_val);
    check(rd_val, 16'h1f1f);
    reg_write(ADDR_CLOCK_RATIO_RESULT, 16'hffff);
    reg_read(ADDR_CLOCK_RATIO_RESULT, rd_val);
    check(rd_val, 16'h0000);
    reg_read(8'h0c, rd_val);
    check(rd_val, 16'h0000);
    foreach (codes[i]) begin
      reg_write(ADDR_PIN_FUNCTION_SELECT, {3'h0, codes[i], 3'h0, codes[i]});
      for (int k = 0; k < 2; k++) begin
        pattern = pin_events_t'(k ? 9'h0a8 : 9'h155);
        tick;
        l0 = lvl(codes[i], pattern, 1'b0);
        l1 = lvl(codes[i], pattern, 1'b1);
        check({oe0, oe1, out1, oe0 & out0}, {l0, 1'b1, ~l1, l0});
      end
    end
    pattern = pin_events_t'(9'h000);
    reg_write(ADDR_PIN_FUNCTION_SELECT, 16'h0f0f);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        pattern = pin_events_t'(9'h002);
        tick;
        pattern = pin_events_t'(9'h000);
      end
      tick;
      check({13'h0000, out1, oe0, out0}, {13'h0000, k[0] == 1'b0, k[0], k[0]});
    end
    cal_en = 1'b1;
    osc_run = 1'b1;
    repeat (10) tick;
    reg_read(ADDR_CLOCK_RATIO_RESULT, rd_val);
    check(rd_val, 16'h0000);
    // The first count is stored about five slow half periods after enable.
    repeat (3000) tick;
    reg_read(ADDR_CLOCK_RATIO_RESULT, rd_val);
    check(rd_val, {4'h0, RATIO_NOMINAL});
    cal_en = 1'b0;
    repeat (50) tick;
    reg_read(ADDR_CLOCK_RATIO_RESULT, rd_val);
    check(rd_val, {4'h0, RATIO_NOMINAL});
    give_verdict;
  end
endmodule : gpio_alt_function_test
`default_nettype wire
